// ===== hw/mpc_clock_ctl.sv
// memory pll configuration and interface clock gate control, apb slave
// assumes apb master synchronous to clk; pll lock and source ticks synchronous to clk
// Operation
// - delay-line power-down bit set holds ddr dlls powered down; resets to zero.
// - memory pll lock shown as read-only bit; writes to it ignored.
// - synthesizer power-down bit powers pll down and bypasses the reference.
// - post, pre and feedback dividers drive pll configuration; all reset zero.
// - one gating cell per interface, between selected source and its divider.
// - gate bit zero passes the clock; one blocks it; resets to zero.
// - source select codes: interface, application, system, image, memory pll.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
module mpc_clock_ctl
	import mpc_pkg::*;
(
	// clock and reset
	input  wire logic               clk,
	input  wire logic               arst_n,
	// apb slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [PADDR_W-1:0] paddr,
	input  wire logic [31:0]        pwdata,
	input  wire logic [3:0]         pstrb,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	// memory pll
	input  wire logic               mem_pll_locked,
	output mpc_pll_cfg_t            mem_pll_cfg,
	output logic                    ddr_dll_power_down,
	output logic                    mem_pll_power_down,
	// interface clocks
	input  wire logic [NUM_SRC-1:0] src_tick,
	output logic [NUM_IF-1:0]       if_gate,
	output logic [NUM_IF-1:0]       if_clk_tick
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	mpc_pll_cfg_t      pll_cfg_r;
	mpc_pll_cfg_t      pll_cfg_nxt;
	mpc_if_cfg_t       if_cfg_r;
	mpc_if_cfg_t       if_cfg_nxt;
	logic              lock_r;
	logic              lock_nxt;
	logic [31:0]       prdata_r;
	logic [31:0]       prdata_nxt;
	logic              pready_r;
	logic              pready_nxt;
	logic              pslverr_r;
	logic              pslverr_nxt;
	logic              dll_pd_r;
	logic              dll_pd_nxt;
	logic              pll_pd_r;
	logic              pll_pd_nxt;
	logic [31:0]       pll_word;
	logic [31:0]       if_word;
	logic [31:0]       wr_word;
	logic [31:0]       wmask;
	logic              hit_pll;
	logic              hit_if;
	logic              wr_commit;

	// ----------------------------------------------------------------
	// register images
	// ----------------------------------------------------------------
	always_comb begin
		pll_word                                  = 32'h0000_0000;
		pll_word[DLL_OFF_POS]                     = pll_cfg_r.dll_off;
		pll_word[LOCK_POS]                        = lock_r;
		pll_word[BYPASS_POS]                      = pll_cfg_r.bypass;
		pll_word[RANGE_LSB +: 3]                  = pll_cfg_r.range;
		pll_word[POST_DIV_LSB +: 3]               = pll_cfg_r.post_div;
		pll_word[PRE_DIV_LSB +: 5]                = pll_cfg_r.input_pre_divider;
		pll_word[FB_DIV_LSB +: 8]                 = pll_cfg_r.feedback_divider;
		if_word                                   = 32'h0000_0000;
		if_word[GATE_LSB +: NUM_IF]               = if_cfg_r.gate;
		if_word[NUM_IF*SEL_W-1:0]                 = if_cfg_r.sel;
	end

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	always_comb begin
		hit_pll   = (paddr == MEM_PLL_CFG_OFS);
		hit_if    = (paddr == IF_SEL_GATE_OFS);
		wr_commit = psel && penable && pready_r && pwrite && !pslverr_r;
		for (int b = 0; b < 4; b++) begin
			wmask[b*8 +: 8] = {8{pstrb[b]}};
		end
	end

	// a setup cycle prepares the answer so that the access phase completes at once
	always_comb begin
		pready_nxt  = psel && !penable && !pready_r;
		pslverr_nxt = pslverr_r;
		prdata_nxt  = prdata_r;
		if (psel && !penable) begin
			pslverr_nxt = !(hit_pll || hit_if);
			if (pwrite) begin
				prdata_nxt = 32'h0000_0000;
			end else if (hit_pll) begin
				prdata_nxt = pll_word;
			end else if (hit_if) begin
				prdata_nxt = if_word;
			end else begin
				prdata_nxt = 32'h0000_0000;
			end
		end else if (pready_r) begin
			pslverr_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata_r  <= 32'h0000_0000;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			prdata_r  <= prdata_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// ----------------------------------------------------------------
	// memory pll configuration register
	// ----------------------------------------------------------------
	always_comb begin
		pll_cfg_nxt = pll_cfg_r;
		wr_word     = (pll_word & ~wmask) | (pwdata & wmask);
		if (wr_commit && hit_pll) begin
			// lock bit is not writable
			pll_cfg_nxt.dll_off           = wr_word[DLL_OFF_POS];
			pll_cfg_nxt.bypass            = wr_word[BYPASS_POS];
			pll_cfg_nxt.range             = wr_word[RANGE_LSB +: 3];
			pll_cfg_nxt.post_div          = wr_word[POST_DIV_LSB +: 3];
			pll_cfg_nxt.input_pre_divider = wr_word[PRE_DIV_LSB +: 5];
			pll_cfg_nxt.feedback_divider  = wr_word[FB_DIV_LSB +: 8];
		end
		lock_nxt   = mem_pll_locked;
		dll_pd_nxt = pll_cfg_nxt.dll_off;
		pll_pd_nxt = pll_cfg_nxt.bypass;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pll_cfg_r.dll_off           <= MEM_PLL_CFG_RST[DLL_OFF_POS];
			pll_cfg_r.bypass            <= MEM_PLL_CFG_RST[BYPASS_POS];
			pll_cfg_r.range             <= MEM_PLL_CFG_RST[RANGE_LSB +: 3];
			pll_cfg_r.post_div          <= MEM_PLL_CFG_RST[POST_DIV_LSB +: 3];
			pll_cfg_r.input_pre_divider <= MEM_PLL_CFG_RST[PRE_DIV_LSB +: 5];
			pll_cfg_r.feedback_divider  <= MEM_PLL_CFG_RST[FB_DIV_LSB +: 8];
			lock_r                      <= LOCK_RST;
			dll_pd_r                    <= MEM_PLL_CFG_RST[DLL_OFF_POS];
			pll_pd_r                    <= MEM_PLL_CFG_RST[BYPASS_POS];
		end else begin
			pll_cfg_r <= pll_cfg_nxt;
			lock_r    <= lock_nxt;
			dll_pd_r  <= dll_pd_nxt;
			pll_pd_r  <= pll_pd_nxt;
		end
	end

	// ----------------------------------------------------------------
	// interface gate and source select register
	// ----------------------------------------------------------------
	always_comb begin
		if_cfg_nxt = if_cfg_r;
		if (wr_commit && hit_if) begin
			if_cfg_nxt.gate = ((if_word[GATE_LSB +: NUM_IF] & ~wmask[GATE_LSB +: NUM_IF])
				| (pwdata[GATE_LSB +: NUM_IF] & wmask[GATE_LSB +: NUM_IF]));
			if_cfg_nxt.sel  = ((if_word[NUM_IF*SEL_W-1:0] & ~wmask[NUM_IF*SEL_W-1:0])
				| (pwdata[NUM_IF*SEL_W-1:0] & wmask[NUM_IF*SEL_W-1:0]));
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			if_cfg_r.gate <= IF_SEL_GATE_RST[GATE_LSB +: NUM_IF];
			if_cfg_r.sel  <= IF_SEL_GATE_RST[NUM_IF*SEL_W-1:0];
		end else begin
			if_cfg_r <= if_cfg_nxt;
		end
	end

	// ----------------------------------------------------------------
	// gating cells
	// ----------------------------------------------------------------
	for (genvar i = 0; i < NUM_IF; i++) begin : g_cell
		mpc_gate_cell u_cell (
			.clk      (clk),
			.arst_n   (arst_n),
			.src_tick (src_tick),
			.sel      (if_cfg_r.sel[i]),
			.gate     (if_cfg_r.gate[i]),
			.tick_r   (if_clk_tick[i])
		);
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign prdata             = prdata_r;
	assign pready             = pready_r;
	assign pslverr            = pslverr_r;
	assign mem_pll_cfg        = pll_cfg_r;
	assign ddr_dll_power_down = dll_pd_r;
	assign mem_pll_power_down = pll_pd_r;
	assign if_gate            = if_cfg_r.gate;

endmodule : mpc_clock_ctl

// ===== hw/mpc_pkg.sv
// memory pll configuration and interface clock gate control: shared constants and types
// assumes a 32-bit apb slave on a single 50 MHz clock with active-low async reset
package mpc_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int          PADDR_W          = 12;
	localparam logic [11:0] MEM_PLL_CFG_OFS  = 12'h04c;
	localparam logic [11:0] IF_SEL_GATE_OFS  = 12'h0f8;
	localparam logic [31:0] MEM_PLL_CFG_RST  = 32'h0010_0000;
	localparam logic [31:0] IF_SEL_GATE_RST  = 32'h0000_1800;

	// ----------------------------------------------------------------
	// memory pll config fields
	// ----------------------------------------------------------------
	localparam int DLL_OFF_POS  = 21;
	localparam int LOCK_POS     = 20;
	localparam int BYPASS_POS   = 19;
	localparam int RANGE_LSB    = 16;
	localparam int POST_DIV_LSB = 13;
	localparam int PRE_DIV_LSB  = 8;
	localparam int FB_DIV_LSB   = 0;
	localparam logic LOCK_RST   = 1'b1;

	// ----------------------------------------------------------------
	// interface gate / source select fields
	// ----------------------------------------------------------------
	localparam int NUM_IF       = 7;
	localparam int SEL_W        = 3;
	localparam int GATE_LSB     = 21;
	localparam int NUM_SRC      = 5;
	// interface index: bit = GATE_LSB + idx, select lsb = SEL_W * idx
	localparam int IDX_IF       = 0;
	localparam int IDX_DISPLAY  = 1;
	localparam int IDX_SENSOR   = 2;
	localparam int IDX_MEMORY   = 3;
	localparam int IDX_APP_PROC = 4;
	localparam int IDX_USB      = 5;
	localparam int IDX_TVOUT    = 6;

	typedef enum logic [2:0] {
		SRC_IF_PLL    = 3'h0,
		SRC_APP_PLL   = 3'h1,
		SRC_SYS_PLL   = 3'h2,
		SRC_IMAGE_PLL = 3'h3,
		SRC_MEM_PLL   = 3'h4
	} mpc_src_t;

	typedef struct packed {
		logic       dll_off;
		logic       bypass;
		logic [2:0] range;
		logic [2:0] post_div;
		logic [4:0] input_pre_divider;
		logic [7:0] feedback_divider;
	} mpc_pll_cfg_t;

	typedef struct packed {
		logic [NUM_IF-1:0]            gate;
		logic [NUM_IF-1:0][SEL_W-1:0] sel;
	} mpc_if_cfg_t;

endpackage : mpc_pkg

// ===== hw/mpc_gate_cell.sv
// one interface clock gating cell behind a pll source selector
// assumes source clocks arrive as synchronous one-cycle ticks on clk
`timescale 1ns/1ps
module mpc_gate_cell
	import mpc_pkg::*;
(
	// clock and reset
	input  wire logic               clk,
	input  wire logic               arst_n,
	// source ticks and control
	input  wire logic [NUM_SRC-1:0] src_tick,
	input  wire logic [SEL_W-1:0]   sel,
	input  wire logic               gate,
	// gated tick toward the divider
	output logic                    tick_r
);

	logic tick_nxt;

	// ----------------------------------------------------------------
	// select and gate
	// ----------------------------------------------------------------
	always_comb begin
		tick_nxt = 1'b0;
		// codes above the memory pll select nothing
		if (!gate && (sel <= SRC_MEM_PLL)) begin
			tick_nxt = src_tick[sel];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tick_r <= 1'b0;
		end else begin
			tick_r <= tick_nxt;
		end
	end

endmodule : mpc_gate_cell

// ===== verif/mpc_clock_ctl_checker.sv
// checker: apb answer, pll config fields and interface gate relations
// assumes binding onto mpc_clock_ctl, one clock domain
`timescale 1ns/1ps
module mpc_clock_ctl_checker
	import mpc_pkg::*;
(
	// clock and reset
	input wire logic               clk,
	input wire logic               arst_n,
	// apb
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic [PADDR_W-1:0] paddr,
	input wire logic [31:0]        pwdata,
	input wire logic [3:0]         pstrb,
	input wire logic [31:0]        prdata,
	input wire logic               pready,
	input wire logic               pslverr,
	// pll and gates
	input wire logic               mem_pll_locked,
	input wire mpc_pll_cfg_t       mem_pll_cfg,
	input wire logic               ddr_dll_power_down,
	input wire logic               mem_pll_power_down,
	input wire logic [NUM_IF-1:0]  if_gate,
	input wire logic [NUM_IF-1:0]  if_clk_tick
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	logic       setup;
	logic       wr_pll;
	logic       wr_gate;
	logic [1:0] up_r;
	assign setup   = psel && !penable;
	assign wr_pll  = psel && penable && pready && pwrite && pstrb == 4'hf
		&& paddr == MEM_PLL_CFG_OFS;
	assign wr_gate = psel && penable && pready && pwrite && pstrb == 4'hf
		&& paddr == IF_SEL_GATE_OFS;
	// edges since reset release, saturating, so lock sampling has settled
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n) up_r <= 2'h0;
		else if (up_r != 2'h3) up_r <= up_r + 2'h1;
	ready_pulse_a: assert property (setup |=> pready)
		else $error("no ready after setup");
	unmapped_err_a: assert property (setup && paddr != MEM_PLL_CFG_OFS
		&& paddr != IF_SEL_GATE_OFS |=> pready && pslverr && prdata == 32'h0)
		else $error("unmapped not refused");
	dll_down_a: assert property (wr_pll |=> ddr_dll_power_down == $past(pwdata[21]))
		else $error("dll power-down wrong");
	pll_down_a: assert property (wr_pll |=> mem_pll_power_down == $past(pwdata[19]))
		else $error("pll power-down wrong");
	div_cfg_a: assert property (wr_pll |=> mem_pll_cfg ==
		{$past(pwdata[21]), $past(pwdata[19:0])}) else $error("divider config wrong");
	lock_read_a: assert property (setup && !pwrite && paddr == MEM_PLL_CFG_OFS
		&& up_r == 2'h3 && $stable(mem_pll_locked) |=> prdata[20] == $past(mem_pll_locked))
		else $error("lock bit wrong");
	gate_wr_a: assert property (wr_gate |=> if_gate == $past(pwdata[27:21]))
		else $error("gate bits wrong");
	gate_block_a: assert property (1'b1 |=> ($past(if_gate) & if_clk_tick) == 7'h0)
		else $error("gated tick leaked");
endmodule : mpc_clock_ctl_checker

bind mpc_clock_ctl mpc_clock_ctl_checker u_chk (.clk, .arst_n, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .mem_pll_locked, .mem_pll_cfg,
	.ddr_dll_power_down, .mem_pll_power_down, .if_gate, .if_clk_tick);

// ===== verif/mpc_clock_ctl_tb.sv
// testbench for mpc_clock_ctl: apb master tasks, queued read checks, tick gating
// assumes the checker binds itself from its own file
`timescale 1ns/1ps
module mpc_clock_ctl_tb;
	import mpc_pkg::*;
	logic               clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic               mem_pll_locked = 1, pready, pslverr, ddr_dll_power_down;
	logic               mem_pll_power_down;
	logic [PADDR_W-1:0] paddr = '0;
	logic [31:0]        pwdata = '0, prdata, d, e;
	logic [3:0]         pstrb = 4'hf;
	logic [NUM_SRC-1:0] src_tick = '0, tk_prev = '0;
	logic [NUM_IF-1:0]  if_gate, if_clk_tick, gv;
	mpc_pll_cfg_t       mem_pll_cfg;
	logic [32:0]        q[$], m;
	int                 error_cnt = 0, tests_run = 0;
	integer             seed = 32'h49724329;

	mpc_clock_ctl DUT (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .mem_pll_locked, .mem_pll_cfg, .ddr_dll_power_down,
		.mem_pll_power_down, .src_tick, .if_gate, .if_clk_tick);

	always #10 clk = ~clk;
	always @(posedge clk) begin
		src_tick <= NUM_SRC'($random(seed));
		tk_prev <= src_tick;
	end

	task automatic check(input string nm, input logic [31:0] s, input logic [31:0] x);
		tests_run++;
		if (s !== x) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, x, s);
		end
	endtask : check

	// answers are taken off the queue in issue order
	always @(posedge clk)
		if (pready === 1'b1 && q.size() > 0) begin
			m = q.pop_front();
			check("prdata", prdata, m[31:0]);
			check("pslverr", {31'h0, pslverr}, {31'h0, m[32]});
		end

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
			input logic [3:0] s, input logic [32:0] x);
		q.push_back(x);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		pstrb <= s;
		@(posedge clk);
		penable <= 1;
		// only the watchdog ends a wait for an answer that never sees pready
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
		// idle edge so the next call never reassigns a strobe in this time step
		@(posedge clk);
	endtask : apb

	task automatic complete_run;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : complete_run

	initial begin
		#200000;
		error_cnt++;
		complete_run();
	end

	initial begin
		repeat (20) @(posedge clk);
		arst_n <= 1;
		@(posedge clk);
		check("dll_pd", {31'h0, ddr_dll_power_down}, 32'h0);
		check("cfg", {11'h0, mem_pll_cfg}, 32'h0);
		check("gate", {25'h0, if_gate}, 32'h0);
		apb(0, MEM_PLL_CFG_OFS, 32'h0, 4'hf, {1'b0, MEM_PLL_CFG_RST});
		apb(0, IF_SEL_GATE_OFS, 32'h0, 4'hf, {1'b0, IF_SEL_GATE_RST});
		$display("reset test done");
		apb(1, IF_SEL_GATE_OFS, IF_SEL_GATE_RST | 32'h0fe0_0000, 4'hf, 33'h0);
		repeat (4) begin
			d = $random(seed);
			mem_pll_locked <= ~d[20];
			e = (d & 32'h002f_ffff) | {11'h0, ~d[20], 20'h0};
			apb(1, MEM_PLL_CFG_OFS, d, 4'hf, 33'h0);
			@(posedge clk);
			check("dll_pd", {31'h0, ddr_dll_power_down}, {31'h0, d[21]});
			check("pll_pd", {31'h0, mem_pll_power_down}, {31'h0, d[19]});
			check("cfg", {11'h0, mem_pll_cfg}, {11'h0, d[21], d[19:0]});
			apb(0, MEM_PLL_CFG_OFS, 32'h0, 4'hf, {1'b0, e});
		end
		apb(1, MEM_PLL_CFG_OFS, ~d, 4'h2, 33'h0);
		apb(1, 12'h050, 32'hffff_ffff, 4'hf, {1'b1, 32'h0});
		apb(0, 12'h100, 32'h0, 4'hf, {1'b1, 32'h0});
		apb(0, MEM_PLL_CFG_OFS, 32'h0, 4'hf, {1'b0, e ^ 32'h0000_ff00});
		mem_pll_locked <= 1'b1;
		@(posedge clk);
		// the lock bit reads back as set once the reconfigured pll reports locked again
		apb(0, MEM_PLL_CFG_OFS, 32'h0, 4'hf,
			{1'b0, (e ^ 32'h0000_ff00) | 32'h0010_0000});
		$display("pll config test done");
		e = IF_SEL_GATE_RST | 32'h0fe0_0000;
		for (int c = 0; c < 8; c++) begin
			gv = NUM_IF'($random(seed));
			d = {4'h0, gv, {7{c[2:0]}}};
			apb(1, IF_SEL_GATE_OFS, e | 32'h0fe0_0000, 4'hf, 33'h0);
			apb(1, IF_SEL_GATE_OFS, d | 32'h0fe0_0000, 4'hf, 33'h0);
			apb(1, IF_SEL_GATE_OFS, d, 4'hf, 33'h0);
			apb(0, IF_SEL_GATE_OFS, 32'h0, 4'hf, {1'b0, d});
			check("gate", {25'h0, if_gate}, {25'h0, gv});
			repeat (6) begin
				@(posedge clk);
				check("tick", {25'h0, if_clk_tick},
					{25'h0, (c < 5) ? ~gv & {7{tk_prev[c[2:0]]}} : 7'h0});
			end
			e = d;
		end
		$display("gate test done");
		check("pending", q.size(), 32'h0);
		complete_run();
	end
endmodule : mpc_clock_ctl_tb
